// file: link_cap_ctl_regs.sv
`timescale 1ns/10ps
`include "link_regs_consts.svh"
module link_cap_ctl_regs
   import link_regs_pkg::*;
#(
   parameter logic [7:0] PORT_NUM   = 8'h00,
   parameter bit         DOWNSTREAM = 1'b1,
   parameter int         AW         = 12
) (
   input  wire logic          SYS_CLK,
   input  wire logic          RST,
   input  wire logic [AW-1:0] ADDR,
   input  wire logic [31:0]   WDATA,
   input  wire logic          WR,
   input  wire logic          RD,
   output logic      [31:0]   RDATA,
   input  wire logic          EE_LOAD,
   input  wire logic [1:0]    EE_ASPM,
   input  wire logic          LTSSM_IN_TRAINING,
   input  wire logic          LTSSM_TRAINING_DONE,
   input  wire logic          DL_DOWN,
   input  wire logic          BW_AUTO_EVENT,
   output logic               RETRAIN_REQ,
   output logic               LINK_OFF,
   output logic               TX_L0S_EN,
   output logic               L1_EN,
   output logic               SHARED_REFCLK,
   output logic               EXTRA_SYNC_SETS,
   output logic               TRAINING_ACTIVE,
   output logic               LINK_IRQ
);
   link_ctl_if lc ();

   localparam logic BWN_CAP = DOWNSTREAM;

   ctl_s        ctl_r;
   ctl_s        ctl_nxt;
   ctl_s        applied_r;
   logic        pending_r;
   logic        bw_mgmt_flag_r;
   logic        bw_auto_flag_r;
   logic [31:0] rdata_nxt;
   logic        wr_ctl;
   logic        wr_sts;
   logic        retrain_wr;
   logic [31:0] cap_val;
   logic [15:0] ctl_val;
   logic [15:0] sts_val;

   // Register write decode
   assign wr_ctl = WR && (ADDR == AW'(`OFS_LINK_CONTROL));
   // Status flags sit in the upper half of the control word
   assign wr_sts = WR && (ADDR == AW'(`OFS_LINK_CONTROL));
   assign retrain_wr = wr_ctl && WDATA[`CTL_RETRAIN_BIT] && DOWNSTREAM;

   // Next control fields from a write, with hardwired enables
   always_comb begin
      ctl_nxt = ctl_r;
      if (wr_ctl) begin
         ctl_nxt.aspm            = WDATA[`CTL_ASPM_MSB:`CTL_ASPM_LSB];
         ctl_nxt.link_off        = WDATA[`CTL_OFF_BIT];
         ctl_nxt.shared_refclk   = WDATA[`CTL_SHCLK_BIT];
         ctl_nxt.extra_sync_sets = WDATA[`CTL_XSYNC_BIT];
         ctl_nxt.bw_mgmt_irq_en  = WDATA[`CTL_BWM_IE_BIT] && BWN_CAP && DOWNSTREAM;
         ctl_nxt.bw_auto_irq_en  = WDATA[`CTL_BWA_IE_BIT] && BWN_CAP && DOWNSTREAM;
      end
   end

   // Software-visible control register, EEPROM load overrides ASPM
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         ctl_r <= ctl_s'('0);
      end else begin
         ctl_r <= ctl_nxt;
         if (EE_LOAD) begin
            ctl_r.aspm <= EE_ASPM;
         end
      end
   end

   // Fields applied to the link; deferred while training after a retrain write made during training
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         applied_r <= ctl_s'('0);
         pending_r <= 1'b0;
      end else if (retrain_wr && LTSSM_IN_TRAINING) begin
         pending_r <= 1'b1;
      end else if (!(pending_r && LTSSM_IN_TRAINING)) begin
         // A write in the cycle training ends goes out with the deferred fields
         pending_r <= 1'b0;
         applied_r <= ctl_nxt;
         if (EE_LOAD) begin
            applied_r.aspm <= EE_ASPM;
         end
      end
   end

   // Retrain pulse toward the training state machine
   assign lc.retrain_pulse = retrain_wr;
   assign lc.in_training   = LTSSM_IN_TRAINING;
   assign lc.training_done = LTSSM_TRAINING_DONE;
   assign lc.link_down     = DL_DOWN;

   link_retrain_seq u_seq (
      .clk (SYS_CLK),
      .rst (RST),
      .lc  (lc.seq)
   );

   // Bandwidth status flags; a set beats a same-cycle clear
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         bw_mgmt_flag_r <= 1'b0;
         bw_auto_flag_r <= 1'b0;
      end else begin
         if (lc.bw_mgmt_set && BWN_CAP && DOWNSTREAM) begin
            bw_mgmt_flag_r <= 1'b1;
         end else if (wr_sts && WDATA[`STS_BWM_BIT + 16]) begin
            bw_mgmt_flag_r <= 1'b0;
         end
         if (BW_AUTO_EVENT && BWN_CAP && DOWNSTREAM) begin
            bw_auto_flag_r <= 1'b1;
         end else if (wr_sts && WDATA[`STS_BWA_BIT + 16]) begin
            bw_auto_flag_r <= 1'b0;
         end
      end
   end

   // Outputs toward the physical layer and interrupt logic
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         RETRAIN_REQ     <= 1'b0;
         LINK_OFF        <= 1'b0;
         TX_L0S_EN       <= 1'b0;
         L1_EN           <= 1'b0;
         SHARED_REFCLK   <= 1'b0;
         EXTRA_SYNC_SETS <= 1'b0;
         TRAINING_ACTIVE <= 1'b0;
         LINK_IRQ        <= 1'b0;
      end else begin
         RETRAIN_REQ     <= retrain_wr;
         LINK_OFF        <= applied_r.link_off && DOWNSTREAM;
         TX_L0S_EN       <= applied_r.aspm[0];
         L1_EN           <= applied_r.aspm[1];
         SHARED_REFCLK   <= applied_r.shared_refclk;
         EXTRA_SYNC_SETS <= applied_r.extra_sync_sets;
         TRAINING_ACTIVE <= lc.training_active && DOWNSTREAM;
         LINK_IRQ        <= (bw_mgmt_flag_r && ctl_r.bw_mgmt_irq_en) ||
                            (bw_auto_flag_r && ctl_r.bw_auto_irq_en);
      end
   end

   // Read views of the registers
   always_comb begin
      cap_val = 32'h0;
      cap_val[`CAP_BWN_BIT] = BWN_CAP;
      cap_val[`CAP_PORT_MSB:`CAP_PORT_LSB] = PORT_NUM;
      ctl_val = 16'h0;
      ctl_val[`CTL_ASPM_MSB:`CTL_ASPM_LSB] = ctl_r.aspm;
      ctl_val[`CTL_RCB_BIT]     = 1'b0;
      ctl_val[`CTL_OFF_BIT]     = ctl_r.link_off;
      ctl_val[`CTL_RETRAIN_BIT] = 1'b0;
      ctl_val[`CTL_SHCLK_BIT]   = ctl_r.shared_refclk;
      ctl_val[`CTL_XSYNC_BIT]   = ctl_r.extra_sync_sets;
      ctl_val[`CTL_CPM_BIT]     = 1'b0;
      ctl_val[`CTL_AUTO_WIDTH_BLOCK_BIT]    = 1'b0;
      ctl_val[`CTL_BWM_IE_BIT]  = ctl_r.bw_mgmt_irq_en;
      ctl_val[`CTL_BWA_IE_BIT]  = ctl_r.bw_auto_irq_en;
      sts_val = 16'h0;
      sts_val[`STS_TRAIN_BIT] = lc.training_active && DOWNSTREAM;
      sts_val[`STS_BWM_BIT]   = bw_mgmt_flag_r;
      sts_val[`STS_BWA_BIT]   = bw_auto_flag_r;
      if (ADDR == AW'(`OFS_LINK_CAPABILITIES)) begin
         rdata_nxt = cap_val;
      end else if (ADDR == AW'(`OFS_LINK_CONTROL)) begin
         rdata_nxt = {sts_val, ctl_val};
      end else begin
         rdata_nxt = 32'h0;
      end
   end

   // Read data stands one cycle after the strobe only
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         RDATA <= 32'h0;
      end else begin
         RDATA <= RD ? rdata_nxt : 32'h0;
      end
   end
endmodule

// file: link_cap_ctl_regs_checker.sv
`timescale 1ns/10ps
// Port-level watch on the link capability and control register block
module link_cap_ctl_regs_checker
   import link_regs_pkg::*;
#(
   parameter logic [7:0] PORT_NUM   = 8'h00,
   parameter bit         DOWNSTREAM = 1'b1,
   parameter int         AW         = 12
) (
   input wire logic          SYS_CLK,
   input wire logic          RST,
   input wire logic [AW-1:0] ADDR,
   input wire logic [31:0]   WDATA,
   input wire logic          WR,
   input wire logic          RD,
   input wire logic [31:0]   RDATA,
   input wire logic          EE_LOAD,
   input wire logic          LTSSM_IN_TRAINING,
   input wire logic          LTSSM_TRAINING_DONE,
   input wire logic          BW_AUTO_EVENT,
   input wire logic          RETRAIN_REQ,
   input wire logic          LINK_OFF,
   input wire logic          TX_L0S_EN,
   input wire logic          L1_EN,
   input wire logic          TRAINING_ACTIVE,
   input wire logic          LINK_IRQ
);
   localparam logic [AW-1:0] CTL_A = AW'(12'h050);
   localparam logic [AW-1:0] CAP_A = AW'(12'h04c);
   logic                     auto_en_r;

   // Remembers the last written autonomous interrupt enable
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) auto_en_r <= 1'b0;
      else if (WR && ADDR == CTL_A) auto_en_r <= WDATA[11];
   end

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   // Retrain write, and a quiet flag clear of both status bits
   sequence rt_wr_s;
      WR && ADDR == CTL_A && WDATA[5];
   endsequence
   sequence clr_s;
      !LTSSM_IN_TRAINING ##1
      WR && ADDR == CTL_A && WDATA[31:30] == 2'b11 && !BW_AUTO_EVENT && !LTSSM_TRAINING_DONE
      && !LTSSM_IN_TRAINING ##1 !BW_AUTO_EVENT && !LTSSM_TRAINING_DONE && !LTSSM_IN_TRAINING;
   endsequence

   retrain_pulse_a: assert property (rt_wr_s |=> RETRAIN_REQ || !DOWNSTREAM)
      else $error("retrain write gave no request pulse");
   retrain_cause_a: assert property (RETRAIN_REQ |-> $past(WR && ADDR == CTL_A && WDATA[5]))
      else $error("retrain request without a retrain write");
   train_flag_a: assert property (rt_wr_s |=> TRAINING_ACTIVE || !DOWNSTREAM)
      else $error("training indication not set by retrain write");
   read_idle_a: assert property (!$past(RD) |-> RDATA == 32'h0)
      else $error("read data not zero outside read slot");
   cap_read_a: assert property (RD && ADDR == CAP_A |=>
      RDATA[31:21] == {PORT_NUM, 2'b00, DOWNSTREAM})
      else $error("capability port number or notify bit wrong");
   ctl_fixed_a: assert property (RD && ADDR == CTL_A |=>
      RDATA[15:12] == 4'h0 && RDATA[9:8] == 2'h0 && RDATA[5] == 1'b0 && RDATA[3:2] == 2'h0)
      else $error("fixed control bits not zero");
   off_apply_a: assert property (WR && ADDR == CTL_A && !LTSSM_IN_TRAINING |=> ##1
      LINK_OFF == ($past(WDATA[4], 2) && DOWNSTREAM))
      else $error("link off output does not follow write");
   aspm_apply_a: assert property (
      WR && ADDR == CTL_A && !LTSSM_IN_TRAINING && !EE_LOAD |=> ##1
      {L1_EN, TX_L0S_EN} == $past(WDATA[1:0], 2))
      else $error("power state enables do not follow write");
   auto_irq_a: assert property (BW_AUTO_EVENT && auto_en_r && !WR |->
      ##[1:3] (LINK_IRQ || !DOWNSTREAM))
      else $error("autonomous event raised no interrupt");
   irq_clear_a: assert property (clr_s |=> !LINK_IRQ)
      else $error("interrupt stays after flags cleared");
endmodule

// file: link_ctl_if.sv
`timescale 1ns/10ps
// Retrain pulse and training handshake shared between the register file and the sequencer
interface link_ctl_if;
   import link_regs_pkg::*;
   logic retrain_pulse;
   logic in_training;
   logic training_done;
   logic link_down;
   logic bw_mgmt_set;
   logic training_active;

   modport regs (output retrain_pulse, input bw_mgmt_set, input training_active);
   modport seq  (input retrain_pulse, input in_training, input training_done,
                 input link_down, output bw_mgmt_set, output training_active);
endinterface

// file: link_regs_consts.svh
`ifndef LINK_REGS_CONSTS_SVH
`define LINK_REGS_CONSTS_SVH

// Register byte offsets
`define OFS_LINK_CONTROL      12'h050
`define OFS_LINK_CAPABILITIES 12'h04c
`define OFS_LINK_STATUS       12'h052
`define OFS_LINK_EVENTS       12'h060

// Link capability field positions
`define CAP_BWN_BIT   21
`define CAP_PORT_LSB  24
`define CAP_PORT_MSB  31

// Link control field positions
`define CTL_ASPM_LSB   0
`define CTL_ASPM_MSB   1
`define CTL_RCB_BIT    3
`define CTL_OFF_BIT    4
`define CTL_RETRAIN_BIT 5
`define CTL_SHCLK_BIT  6
`define CTL_XSYNC_BIT  7
`define CTL_CPM_BIT    8
`define CTL_AUTO_WIDTH_BLOCK_BIT   9
`define CTL_BWM_IE_BIT 10
`define CTL_BWA_IE_BIT 11

// Link status field positions
`define STS_TRAIN_BIT  11
`define STS_BWM_BIT    14
`define STS_BWA_BIT    15

// Reset values
`define CTL_RESET      16'h0000
`define ASPM_RESET     2'h0

`endif

// file: link_regs_pkg.sv
package link_regs_pkg;
   typedef enum logic [1:0] {
      ASPM_OFF  = 2'h0,
      ASPM_L0S  = 2'h1,
      ASPM_L1   = 2'h2,
      ASPM_BOTH = 2'h3
   } aspm_e;

   typedef enum logic [2:0] {
      RT_IDLE = 3'b001,
      RT_WAIT = 3'b010,
      RT_BUSY = 3'b100
   } retrain_e;

   typedef struct packed {
      logic [1:0] aspm;
      logic       link_off;
      logic       shared_refclk;
      logic       extra_sync_sets;
      logic       bw_mgmt_irq_en;
      logic       bw_auto_irq_en;
   } ctl_s;
endpackage

// file: link_retrain_seq.sv
`timescale 1ns/10ps
// Tracks a software retrain from request through completion
module link_retrain_seq
   import link_regs_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst,
   link_ctl_if.seq   lc
);
   retrain_e state_r;
   logic     clean_r;

   // Sequence: request, wait for training start, wait for end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= RT_IDLE;
      end else begin
         case (state_r)
            RT_IDLE: if (lc.retrain_pulse) state_r <= lc.in_training ? RT_BUSY : RT_WAIT;
            RT_WAIT: if (lc.in_training) state_r <= RT_BUSY;
            RT_BUSY: if (lc.training_done || !lc.in_training) state_r <= RT_IDLE;
            default: state_r <= RT_IDLE;
         endcase
      end
   end

   // Remembers whether data-link-down was seen during this retrain
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clean_r <= 1'b0;
      end else if (lc.retrain_pulse) begin
         clean_r <= 1'b1;
      end else if (lc.link_down) begin
         clean_r <= 1'b0;
      end
   end

   // Training indication is set at the write, before training begins
   assign lc.training_active = (state_r != RT_IDLE) || lc.retrain_pulse || lc.in_training;
   assign lc.bw_mgmt_set = (state_r == RT_BUSY) && (lc.training_done || !lc.in_training)
                           && clean_r && !lc.link_down;
endmodule

// file: tb_link_cap_ctl_regs.sv
`timescale 1ns/10ps
module tb_link_cap_ctl_regs import link_regs_pkg::*; ;
   localparam logic [7:0] PNUM = 8'h05;
   logic        sys_clk, rst, wr, rd, ee_load, in_trn, trn_done, dl_down, auto_ev;
   logic        retrain_req, link_off, l0s_en, l1_en, refclk, xsync, trn_act, irq;
   logic [1:0]  ee_aspm;
   logic [11:0] addr;
   logic [31:0] wdata, rdata;
   int          miscompares, compares, ctl_m;

   link_cap_ctl_regs #(.PORT_NUM(PNUM), .DOWNSTREAM(1'b1), .AW(12)) i_link_cap_ctl_regs (
      .SYS_CLK(sys_clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .EE_LOAD(ee_load), .EE_ASPM(ee_aspm), .LTSSM_IN_TRAINING(in_trn),
      .LTSSM_TRAINING_DONE(trn_done), .DL_DOWN(dl_down), .BW_AUTO_EVENT(auto_ev),
      .RETRAIN_REQ(retrain_req), .LINK_OFF(link_off), .TX_L0S_EN(l0s_en), .L1_EN(l1_en),
      .SHARED_REFCLK(refclk), .EXTRA_SYNC_SETS(xsync), .TRAINING_ACTIVE(trn_act),
      .LINK_IRQ(irq));

   // Clock and watchdog
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   initial begin
      #200000;
      miscompares++;
      report_and_stop;
   end

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
      compares++;
      if ((got & msk) !== (exp & msk)) begin
         miscompares++;
         $display("mismatch at %0t ns: got %h expected %h", $time, got & msk, exp & msk);
      end
   endtask

   // Register bus cycles
   task automatic wr32(input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask
   task automatic rd32(input logic [11:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic chk_ctl(input logic [31:0] sts);
      logic [31:0] d;
      rd32(12'h050, d);
      cmp(d, sts | ctl_m, 32'hc800_ffff);
   endtask

   task automatic report_and_stop;
      if (miscompares == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      logic [31:0] d;
      logic [31:0] w;
      aspm_e       codes[4];
      {rst, wr, rd, ee_load, in_trn, trn_done, dl_down, auto_ev} = 8'h80;
      {addr, wdata, ee_aspm} = 46'h0;
      miscompares = 0;
      compares = 0;
      ctl_m = 0;
      codes = '{ASPM_OFF, ASPM_L0S, ASPM_L1, ASPM_BOTH};
      w = $urandom(88);
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      rd32(12'h04c, d);
      cmp(d, {PNUM, 3'b001, 21'h0}, 32'hffe0_0000);
      chk_ctl(32'h0);
      // Random control values, no retrain and no flag clear
      for (int i = 0; i < 8; i++) begin
         w = $urandom & 32'h0000_ffdf;
         wr32(12'h050, w);
         ctl_m = w & 32'h0cd3;
         chk_ctl(32'h0);
         cmp({link_off, refclk, xsync, l1_en, l0s_en}, {w[4], w[6], w[7], w[1:0]}, 32'h1f);
      end
      // Unmapped place ignores writes and reads zero
      wr32(12'h0f0, 32'hffff_ffff);
      chk_ctl(32'h0);
      rd32(12'h0f0, d);
      cmp(d, 32'h0, 32'hffff_ffff);
      // Every power state code loaded from the boot memory
      foreach (codes[i]) begin
         @(posedge sys_clk);
         ee_load <= 1'b1;
         ee_aspm <= codes[i];
         @(posedge sys_clk);
         ee_load <= 1'b0;
         ctl_m = (ctl_m & 32'hfffc) | i;
         chk_ctl(32'h0);
         cmp({l1_en, l0s_en}, i, 32'h3);
      end
      // Retrain with field changes in one write, clean completion
      wr32(12'h050, 32'h0000_0460);
      ctl_m = 32'h0440;
      #1 cmp({retrain_req, trn_act}, 2'b11, 32'h3);
      @(posedge sys_clk);
      #1 cmp({retrain_req, trn_act, refclk}, 3'b011, 32'h7);
      chk_ctl(32'h0800_0000);
      @(posedge sys_clk);
      in_trn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      in_trn <= 1'b0;
      trn_done <= 1'b1;
      @(posedge sys_clk);
      trn_done <= 1'b0;
      chk_ctl(32'h4000_0000);
      cmp(irq, 1, 1);
      wr32(12'h050, 32'hc000_0000 | ctl_m);
      @(posedge sys_clk);
      #1 cmp(irq, 0, 1);
      // Retrain while training: fields wait, link drop blocks the flag
      @(posedge sys_clk);
      in_trn <= 1'b1;
      wr32(12'h050, 32'h0000_0ca0);
      @(posedge sys_clk);
      dl_down <= 1'b1;
      #1 cmp({refclk, xsync}, 2'b10, 32'h3);
      @(posedge sys_clk);
      in_trn <= 1'b0;
      dl_down <= 1'b0;
      ctl_m = 32'h0c80;
      chk_ctl(32'h0);
      cmp({refclk, xsync}, 2'b01, 32'h3);
      // Autonomous bandwidth change raises and clears the interrupt
      @(posedge sys_clk);
      auto_ev <= 1'b1;
      @(posedge sys_clk);
      auto_ev <= 1'b0;
      chk_ctl(32'h8000_0000);
      cmp(irq, 1, 1);
      wr32(12'h050, 32'hc000_0000 | ctl_m);
      @(posedge sys_clk);
      #1 cmp(irq, 0, 1);
      report_and_stop;
   end
endmodule

bind link_cap_ctl_regs link_cap_ctl_regs_checker #(.PORT_NUM(PORT_NUM), .DOWNSTREAM(DOWNSTREAM),
   .AW(AW)) i_chk (.SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
   .RDATA(RDATA), .EE_LOAD(EE_LOAD), .LTSSM_IN_TRAINING(LTSSM_IN_TRAINING),
   .LTSSM_TRAINING_DONE(LTSSM_TRAINING_DONE), .BW_AUTO_EVENT(BW_AUTO_EVENT),
   .RETRAIN_REQ(RETRAIN_REQ), .LINK_OFF(LINK_OFF), .TX_L0S_EN(TX_L0S_EN), .L1_EN(L1_EN),
   .TRAINING_ACTIVE(TRAINING_ACTIVE), .LINK_IRQ(LINK_IRQ));
